// ---- inc/dsp_pkg.sv ----
`default_nettype none
package dsp_pkg;
  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_CTRL_A = 8'h80;
  localparam logic [7:0] ADDR_CTRL_B = 8'h81;
  localparam logic [7:0] ADDR_CNT_L  = 8'h84;
  localparam logic [7:0] ADDR_CNT_H  = 8'h85;
  localparam logic [7:0] ADDR_CAP_L  = 8'h86;
  localparam logic [7:0] ADDR_CAP_H  = 8'h87;
  localparam logic [7:0] ADDR_CMPA_L = 8'h88;
  localparam logic [7:0] ADDR_CMPA_H = 8'h89;
  localparam logic [7:0] ADDR_CMPB_L = 8'h8A;
  localparam logic [7:0] ADDR_CMPB_H = 8'h8B;
  localparam logic [7:0] ADDR_FLAGS  = 8'h8C;
  localparam logic [7:0] ADDR_PINDIR = 8'h8D;
  // ---------------------------------------------------------------
  // Fields and reset values
  // ---------------------------------------------------------------
  localparam int         CA_ACT_A_LSB  = 6;
  localparam int         CA_ACT_B_LSB  = 4;
  localparam int         CA_WSEL_LSB   = 0;
  localparam int         CB_WSEL_LSB   = 3;
  localparam int         CB_CLKSEL_LSB = 0;
  localparam logic [7:0] CTRL_A_MASK   = 8'hF3;
  localparam logic [7:0] CTRL_B_MASK   = 8'h1F;
  localparam logic [7:0] CTRL_RST      = 8'h00;
  localparam logic [15:0] WORD_RST     = 16'h0000;
  localparam int         FLAG_OVF      = 0;
  localparam int         FLAG_CMPA     = 1;
  localparam int         FLAG_CMPB     = 2;
  localparam int         FLAG_CAP      = 3;
  // ---------------------------------------------------------------
  // Counter limits, modes and actions
  // ---------------------------------------------------------------
  localparam logic [15:0] CNT_BOTTOM = 16'h0000;
  localparam logic [15:0] CNT_MAX    = 16'hFFFF;
  localparam logic [15:0] TOP_8BIT   = 16'h00FF;
  localparam logic [15:0] TOP_9BIT   = 16'h01FF;
  localparam logic [15:0] TOP_10BIT  = 16'h03FF;
  localparam logic [1:0] ACT_OFF    = 2'h0;
  localparam logic [1:0] ACT_TOGGLE = 2'h1;
  localparam logic [1:0] ACT_CLEAR  = 2'h2;
  localparam logic [1:0] ACT_SET    = 2'h3;
  localparam logic [9:0] DIV8_MASK    = 10'h007;
  localparam logic [9:0] DIV64_MASK   = 10'h03F;
  localparam logic [9:0] DIV256_MASK  = 10'h0FF;
  localparam logic [9:0] DIV1024_MASK = 10'h3FF;
  typedef enum logic [2:0]
  {
    MODE_NORMAL = 3'b000,
    MODE_CTC    = 3'b001,
    MODE_FAST   = 3'b010,
    MODE_PC     = 3'b011,
    MODE_PFC    = 3'b100
  } dsp_mode_e;
endpackage
`default_nettype wire

// ---- inc/dsp_tmr_if.sv ----
`default_nettype none
interface dsp_tmr_if;
  logic              tick;
  logic [15:0]       cnt;
  logic [15:0]       top;
  dsp_pkg::dsp_mode_e mode;
  logic [3:0]        wsel;
  logic              dirUp;
  logic              atTop;
  modport timer (output tick, cnt, top, mode, wsel, dirUp, atTop);
  modport chan (input tick, cnt, top, mode, wsel, dirUp, atTop);
endinterface
`default_nettype wire

// ---- src/dsp_prescaler.sv ----
`default_nettype none
module dsp_prescaler (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [2:0] clkSel,
  output logic            tick
);
  logic [9:0] pre_r;
  logic [9:0] pre_nxt;

  always_comb
  begin
    pre_nxt = pre_r + 10'h001;
    case (clkSel)
      3'h1:    tick = 1'b1;
      3'h2:    tick = (pre_r & dsp_pkg::DIV8_MASK) == dsp_pkg::DIV8_MASK;
      3'h3:    tick = (pre_r & dsp_pkg::DIV64_MASK) == dsp_pkg::DIV64_MASK;
      3'h4:    tick = (pre_r & dsp_pkg::DIV256_MASK)
                      == dsp_pkg::DIV256_MASK;
      3'h5:    tick = pre_r == dsp_pkg::DIV1024_MASK;
      default: tick = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      pre_r <= 10'h000;
    else if (ce)
      pre_r <= pre_nxt;
  end
endmodule
`default_nettype wire

// ---- src/dsp_pwm_top.sv ----
// Functional notes
// - Dual slope: count zero to TOP and back.
// - Mode 8 TOP capture, mode 9 compare A.
// - Counter holds TOP one timer tick.
// - Counter equal compare value sets match flag.
// - Buffered compares load with overflow, except phase correct loads at TOP.
// - TOP source flag set on reaching TOP.
// - Compare above TOP never matches.
// - Action 2 non-inverted, 3 inverted PWM.
// - Output flips on up and down matches.
// - Non-inverting clears up, sets down.
// - Pin driven only when direction is output.
// - Dual slope: compare BOTTOM low, TOP high, non-inverted.
// - Mode 9 action 1 toggles A.
// - Divider 1, 8, 64, 256, 1024 selectable.
// - Everything on I/O clock, tick enables.
// - Control A: A 7:6, B 5:4, mode 1:0.
// - Nonzero action overrides pin port function, except a toggle the mode disallows.
// - Non-PWM: off, toggle, clear, set.
// - Fast PWM toggle only A, modes 14/15.
// - Fast PWM clear or set, BOTTOM opposite.
// - Upper mode bits live in control B.
//
// Added by the designer: strobed register access.
`default_nettype none
module dsp_pwm_top (
  input  wire logic       ref_clk,
  input  wire logic       nrst,
  input  wire logic       ce,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrEn,
  input  wire logic       rdEn,
  output logic [7:0]      rdData,
  output logic            waveformOutputA,
  output logic            waveformOutputAOe,
  output logic            waveformOutputB,
  output logic            waveformOutputBOe
);
  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  logic [7:0]  ctrlA_r;
  logic [7:0]  ctrlA_nxt;
  logic [7:0]  ctrlB_r;
  logic [7:0]  ctrlB_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic        up_r;
  logic        up_nxt;
  logic [15:0] capTop_r;
  logic [15:0] capTop_nxt;
  logic [15:0] bufA_r;
  logic [15:0] bufA_nxt;
  logic [15:0] bufB_r;
  logic [15:0] bufB_nxt;
  logic [15:0] actA_r;
  logic [15:0] actA_nxt;
  logic [15:0] actB_r;
  logic [15:0] actB_nxt;
  logic [3:0]  flags_r;
  logic [3:0]  flags_nxt;
  logic [1:0]  pinDir_r;
  logic [1:0]  pinDir_nxt;
  logic [7:0]  tmp_r;
  logic [7:0]  tmp_nxt;
  logic [7:0]  rdData_r;
  logic [7:0]  rdData_nxt;

  // ---------------------------------------------------------------
  // Mode decode
  // ---------------------------------------------------------------
  logic [3:0]         wsel;
  dsp_pkg::dsp_mode_e mode;
  logic [15:0]        topVal;
  logic               capIsTop;
  logic               aIsTop;
  logic               dual;
  logic               atTop;
  logic               atBot;
  logic               pastTop;
  logic               dirUp;
  logic               tick;
  logic               updNow;
  logic               matchA;
  logic               matchB;
  logic [3:0]         setEv;
  logic [3:0]         clrEv;

  assign wsel = {ctrlB_r[dsp_pkg::CB_WSEL_LSB +: 2],
                 ctrlA_r[dsp_pkg::CA_WSEL_LSB +: 2]};

  always_comb
  begin
    mode = dsp_pkg::MODE_NORMAL;
    topVal = dsp_pkg::CNT_MAX;
    capIsTop = 1'b0;
    aIsTop = 1'b0;
    case (wsel)
      4'h1, 4'h2, 4'h3:
      begin
        mode = dsp_pkg::MODE_PC;
        topVal = wsel[1] ? (wsel[0] ? dsp_pkg::TOP_10BIT
                                    : dsp_pkg::TOP_9BIT)
                         : dsp_pkg::TOP_8BIT;
      end
      4'h5, 4'h6, 4'h7:
      begin
        mode = dsp_pkg::MODE_FAST;
        topVal = wsel[1] ? (wsel[0] ? dsp_pkg::TOP_10BIT
                                    : dsp_pkg::TOP_9BIT)
                         : dsp_pkg::TOP_8BIT;
      end
      4'h4, 4'hC:
      begin
        mode = dsp_pkg::MODE_CTC;
        capIsTop = wsel[3];
        aIsTop = ~wsel[3];
      end
      4'h8, 4'h9:
      begin
        mode = dsp_pkg::MODE_PFC;
        capIsTop = ~wsel[0];
        aIsTop = wsel[0];
      end
      4'hA, 4'hB:
      begin
        mode = dsp_pkg::MODE_PC;
        capIsTop = ~wsel[0];
        aIsTop = wsel[0];
      end
      4'hE, 4'hF:
      begin
        mode = dsp_pkg::MODE_FAST;
        capIsTop = ~wsel[0];
        aIsTop = wsel[0];
      end
      default:
      begin
        mode = dsp_pkg::MODE_NORMAL;
      end
    endcase
    if (capIsTop)
      topVal = capTop_r;
    else if (aIsTop)
      topVal = actA_r;
    dual = (mode == dsp_pkg::MODE_PC) || (mode == dsp_pkg::MODE_PFC);
    atTop = cnt_r == topVal;
    atBot = cnt_r == dsp_pkg::CNT_BOTTOM;
    // A lowered TOP must not let the rising slope run away to MAX.
    pastTop = cnt_r >= topVal;
    if (!dual)
      dirUp = 1'b1;
    else if (atBot)
      dirUp = 1'b1;
    else if (pastTop)
      dirUp = 1'b0;
    else
      dirUp = up_r;
    case (mode)
      dsp_pkg::MODE_PFC:  updNow = tick && atBot;
      dsp_pkg::MODE_PC:   updNow = tick && atTop;
      dsp_pkg::MODE_FAST: updNow = tick && atTop;
      default:            updNow = 1'b1;
    endcase
  end

  // ---------------------------------------------------------------
  // Timer clock and channels
  // ---------------------------------------------------------------
  dsp_tmr_if tmrIf ();

  assign tmrIf.tick = tick;
  assign tmrIf.cnt = cnt_r;
  assign tmrIf.top = topVal;
  assign tmrIf.mode = mode;
  assign tmrIf.wsel = wsel;
  assign tmrIf.dirUp = dirUp;
  assign tmrIf.atTop = atTop;

  dsp_prescaler uPre (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .clkSel  (ctrlB_r[dsp_pkg::CB_CLKSEL_LSB +: 3]),
    .tick    (tick)
  );

  dsp_wave_chan #(
    .IS_A (1'b1)
  ) uChanA (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .tb      (tmrIf.chan),
    .action  (ctrlA_r[dsp_pkg::CA_ACT_A_LSB +: 2]),
    .cmp     (actA_r),
    .pinDir  (pinDir_r[0]),
    .match   (matchA),
    .pin     (waveformOutputA),
    .pinOe   (waveformOutputAOe)
  );

  dsp_wave_chan #(
    .IS_A (1'b0)
  ) uChanB (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .ce      (ce),
    .tb      (tmrIf.chan),
    .action  (ctrlA_r[dsp_pkg::CA_ACT_B_LSB +: 2]),
    .cmp     (actB_r),
    .pinDir  (pinDir_r[1]),
    .match   (matchB),
    .pin     (waveformOutputB),
    .pinOe   (waveformOutputBOe)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  always_comb
  begin
    ctrlA_nxt = ctrlA_r;
    ctrlB_nxt = ctrlB_r;
    cnt_nxt = cnt_r;
    up_nxt = up_r;
    capTop_nxt = capTop_r;
    bufA_nxt = bufA_r;
    bufB_nxt = bufB_r;
    pinDir_nxt = pinDir_r;
    tmp_nxt = tmp_r;
    rdData_nxt = 8'h00;
    clrEv = 4'h0;
    // The timer clock only enables counting; all state sits on ref_clk.
    if (tick)
    begin
      if (dual)
      begin
        if (dirUp)
        begin
          up_nxt = 1'b1;
          cnt_nxt = cnt_r + 16'h0001;
        end
        else
        begin
          up_nxt = 1'b0;
          cnt_nxt = cnt_r - 16'h0001;
        end
      end
      else if (atTop)
      begin
        up_nxt = 1'b1;
        cnt_nxt = dsp_pkg::CNT_BOTTOM;
      end
      else
      begin
        up_nxt = 1'b1;
        cnt_nxt = cnt_r + 16'h0001;
      end
    end
    // A high byte waits in the shared temporary until its low byte.
    if (wrEn)
    begin
      case (addr)
        dsp_pkg::ADDR_CTRL_A: ctrlA_nxt = wrData & dsp_pkg::CTRL_A_MASK;
        dsp_pkg::ADDR_CTRL_B: ctrlB_nxt = wrData & dsp_pkg::CTRL_B_MASK;
        dsp_pkg::ADDR_CNT_H,
        dsp_pkg::ADDR_CAP_H,
        dsp_pkg::ADDR_CMPA_H,
        dsp_pkg::ADDR_CMPB_H: tmp_nxt = wrData;
        dsp_pkg::ADDR_CNT_L:  cnt_nxt = {tmp_r, wrData};
        dsp_pkg::ADDR_CAP_L:  capTop_nxt = {tmp_r, wrData};
        dsp_pkg::ADDR_CMPA_L: bufA_nxt = {tmp_r, wrData};
        dsp_pkg::ADDR_CMPB_L: bufB_nxt = {tmp_r, wrData};
        dsp_pkg::ADDR_FLAGS:  clrEv = wrData[3:0];
        dsp_pkg::ADDR_PINDIR: pinDir_nxt = wrData[1:0];
        default:              clrEv = 4'h0;
      endcase
    end
    if (rdEn)
    begin
      case (addr)
        dsp_pkg::ADDR_CTRL_A: rdData_nxt = ctrlA_r;
        dsp_pkg::ADDR_CTRL_B: rdData_nxt = ctrlB_r;
        dsp_pkg::ADDR_CNT_L:
        begin
          rdData_nxt = cnt_r[7:0];
          tmp_nxt = cnt_r[15:8];
        end
        dsp_pkg::ADDR_CAP_L:
        begin
          rdData_nxt = capTop_r[7:0];
          tmp_nxt = capTop_r[15:8];
        end
        dsp_pkg::ADDR_CMPA_L:
        begin
          rdData_nxt = bufA_r[7:0];
          tmp_nxt = bufA_r[15:8];
        end
        dsp_pkg::ADDR_CMPB_L:
        begin
          rdData_nxt = bufB_r[7:0];
          tmp_nxt = bufB_r[15:8];
        end
        dsp_pkg::ADDR_CNT_H,
        dsp_pkg::ADDR_CAP_H,
        dsp_pkg::ADDR_CMPA_H,
        dsp_pkg::ADDR_CMPB_H: rdData_nxt = tmp_r;
        dsp_pkg::ADDR_FLAGS:  rdData_nxt = {4'h0, flags_r};
        dsp_pkg::ADDR_PINDIR: rdData_nxt = {6'h00, pinDir_r};
        default:              rdData_nxt = 8'h00;
      endcase
    end
    // Buffers load at the mode's update point; immediate modes follow.
    actA_nxt = updNow ? bufA_nxt : actA_r;
    actB_nxt = updNow ? bufB_nxt : actB_r;
    setEv[dsp_pkg::FLAG_OVF] = tick
      && (dual ? atBot
               : (mode == dsp_pkg::MODE_FAST) ? atTop
                                              : cnt_r == dsp_pkg::CNT_MAX);
    setEv[dsp_pkg::FLAG_CMPA] = matchA
      || (tick && atTop && aIsTop);
    setEv[dsp_pkg::FLAG_CMPB] = matchB;
    setEv[dsp_pkg::FLAG_CAP] = tick && atTop && capIsTop;
    // An event in the clearing cycle survives the write of one.
    flags_nxt = (flags_r & ~clrEv) | setEv;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrlA_r <= dsp_pkg::CTRL_RST;
      ctrlB_r <= dsp_pkg::CTRL_RST;
      cnt_r <= dsp_pkg::WORD_RST;
      up_r <= 1'b1;
      capTop_r <= dsp_pkg::WORD_RST;
      bufA_r <= dsp_pkg::WORD_RST;
      bufB_r <= dsp_pkg::WORD_RST;
      actA_r <= dsp_pkg::WORD_RST;
      actB_r <= dsp_pkg::WORD_RST;
      flags_r <= 4'h0;
      pinDir_r <= 2'h0;
      tmp_r <= 8'h00;
      rdData_r <= 8'h00;
    end
    else if (ce)
    begin
      ctrlA_r <= ctrlA_nxt;
      ctrlB_r <= ctrlB_nxt;
      cnt_r <= cnt_nxt;
      up_r <= up_nxt;
      capTop_r <= capTop_nxt;
      bufA_r <= bufA_nxt;
      bufB_r <= bufB_nxt;
      actA_r <= actA_nxt;
      actB_r <= actB_nxt;
      flags_r <= flags_nxt;
      pinDir_r <= pinDir_nxt;
      tmp_r <= tmp_nxt;
      rdData_r <= rdData_nxt;
    end
  end

  assign rdData = rdData_r;
endmodule
`default_nettype wire

// ---- src/dsp_wave_chan.sv ----
`default_nettype none
module dsp_wave_chan #(
  parameter bit IS_A = 1'b0
) (
  input  wire logic        ref_clk,
  input  wire logic        nrst,
  input  wire logic        ce,
  dsp_tmr_if.chan          tb,
  input  wire logic [1:0]  action,
  input  wire logic [15:0] cmp,
  input  wire logic        pinDir,
  output logic             match,
  output logic             pin,
  output logic             pinOe
);
  logic wave_r;
  logic wave_nxt;
  logic pin_nxt;
  logic oe_nxt;
  logic togOk;
  logic conn;

  always_comb
  begin
    // A compare value above TOP never matches, even when the counter passes it.
    match = tb.tick && (tb.cnt == cmp) && (cmp <= tb.top);
    case (tb.mode)
      dsp_pkg::MODE_NORMAL, dsp_pkg::MODE_CTC: togOk = 1'b1;
      dsp_pkg::MODE_FAST: togOk = IS_A && (tb.wsel[3:1] == 3'h7);
      dsp_pkg::MODE_PC, dsp_pkg::MODE_PFC:
        togOk = IS_A && (tb.wsel[3] && tb.wsel[0]);
      default: togOk = 1'b0;
    endcase
    wave_nxt = wave_r;
    case (tb.mode)
      dsp_pkg::MODE_PC, dsp_pkg::MODE_PFC:
      begin
        if (match)
        begin
          case (action)
            dsp_pkg::ACT_TOGGLE: wave_nxt = togOk ? ~wave_r : wave_r;
            dsp_pkg::ACT_CLEAR:  wave_nxt = ~tb.dirUp;
            dsp_pkg::ACT_SET:    wave_nxt = tb.dirUp;
            default:             wave_nxt = wave_r;
          endcase
        end
      end
      dsp_pkg::MODE_FAST:
      begin
        if (match && action == dsp_pkg::ACT_TOGGLE && togOk)
          wave_nxt = ~wave_r;
        else if (match && action[1] && cmp != tb.top)
          wave_nxt = action[0];
        else if (tb.tick && tb.atTop && action[1])
          wave_nxt = ~action[0];
      end
      default:
      begin
        if (match)
        begin
          case (action)
            dsp_pkg::ACT_TOGGLE: wave_nxt = ~wave_r;
            dsp_pkg::ACT_CLEAR:  wave_nxt = 1'b0;
            dsp_pkg::ACT_SET:    wave_nxt = 1'b1;
            default:             wave_nxt = wave_r;
          endcase
        end
      end
    endcase
    // A toggle code that the mode does not allow leaves the pin to the port.
    conn = (action != dsp_pkg::ACT_OFF)
           && (action != dsp_pkg::ACT_TOGGLE || togOk);
    pin_nxt = conn && wave_nxt;
    oe_nxt = conn && pinDir;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      wave_r <= 1'b0;
      pin <= 1'b0;
      pinOe <= 1'b0;
    end
    else if (ce)
    begin
      wave_r <= wave_nxt;
      pin <= pin_nxt;
      pinOe <= oe_nxt;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/dsp_pwm_checker.sv ----
`default_nettype none
module dsp_pwm_checker (
  input wire logic       ref_clk,
  input wire logic       nrst,
  input wire logic       ce,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic       wrEn,
  input wire logic       rdEn,
  input wire logic [7:0] rdData,
  input wire logic       waveformOutputA,
  input wire logic       waveformOutputAOe,
  input wire logic       waveformOutputB,
  input wire logic       waveformOutputBOe
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  a_rd_idle_zero: assert property (
    $past(ce) && !$past(rdEn) |-> rdData == 8'h00)
    else $error("read data not zero outside a read");
  a_ctla_resv_zero: assert property (
    $past(ce) && $past(rdEn) && $past(addr) == dsp_pkg::ADDR_CTRL_A
    |-> rdData[3:2] == 2'h0) else $error("control A reserved bits set");
  a_ctla_readback: assert property (
    ce && wrEn && addr == dsp_pkg::ADDR_CTRL_A ##1 !wrEn
    ##1 ce && rdEn && addr == dsp_pkg::ADDR_CTRL_A
    |=> rdData == ($past(wrData, 3) & dsp_pkg::CTRL_A_MASK))
    else $error("control A read back differs");
  a_ctlb_resv_zero: assert property (
    $past(ce) && $past(rdEn) && $past(addr) == dsp_pkg::ADDR_CTRL_B
    |-> rdData[7:5] == 3'h0) else $error("control B reserved bits set");
  a_unmapped_zero: assert property (
    $past(ce) && $past(rdEn) && ($past(addr) < dsp_pkg::ADDR_CTRL_A
    || $past(addr) > dsp_pkg::ADDR_PINDIR) |-> rdData == 8'h00)
    else $error("unmapped read not zero");
  a_flags_upper_zero: assert property (
    $past(ce) && $past(rdEn) && $past(addr) == dsp_pkg::ADDR_FLAGS
    |-> rdData[7:4] == 4'h0) else $error("flag register upper bits set");
  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  a_freeze_outputs: assert property (
    !$past(ce) |-> $stable(rdData) && $stable(waveformOutputA)
    && $stable(waveformOutputB)) else $error("outputs moved with ce low");
  // Output enables depend on registers only, so only a write moves them.
  a_oe_needs_write: assert property (
    $changed(waveformOutputAOe) || $changed(waveformOutputBOe)
    |-> $past(wrEn) || $past(wrEn, 2))
    else $error("output enable changed without a write");
  c_pin_b_high: cover property (waveformOutputB && waveformOutputBOe);
  c_pin_a_high: cover property (waveformOutputA && waveformOutputAOe);
  c_frozen: cover property (!ce ##1 !ce);
endmodule
bind dsp_pwm_top dsp_pwm_checker u_chk (
  .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .addr(addr),
  .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
  .waveformOutputA(waveformOutputA), .waveformOutputAOe(waveformOutputAOe),
  .waveformOutputB(waveformOutputB), .waveformOutputBOe(waveformOutputBOe)
);
`default_nettype wire

// ---- testbench/tb_dsp_pwm_top.sv ----
`default_nettype none
module tb_dsp_pwm_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic       ref_clk;
  logic       nrst;
  logic       ce;
  logic [7:0] addr;
  logic [7:0] wrData;
  logic       wrEn;
  logic       rdEn;
  logic [7:0] rdData;
  logic       waveformOutputA;
  logic       waveformOutputAOe;
  logic       waveformOutputB;
  logic       waveformOutputBOe;
  logic [7:0] rv;
  int         error_cnt;
  int         n_tests;
  int         div [4] = '{8, 64, 256, 1024};

  dsp_pwm_top DUT (
    .ref_clk(ref_clk), .nrst(nrst), .ce(ce), .addr(addr),
    .wrData(wrData), .wrEn(wrEn), .rdEn(rdEn), .rdData(rdData),
    .waveformOutputA(waveformOutputA), .waveformOutputAOe(waveformOutputAOe),
    .waveformOutputB(waveformOutputB), .waveformOutputBOe(waveformOutputBOe)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] seen,
                       input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wrData <= d;
    wrEn   <= 1'b1;
    @(posedge ref_clk);
    wrEn   <= 1'b0;
  endtask

  // High byte first: it waits in the shared temporary until the low byte.
  task automatic wr16(input logic [7:0] a, input logic [15:0] d);
    wr(a + 8'h01, d[15:8]);
    wr(a, d[7:0]);
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge ref_clk);
    addr <= a;
    rdEn <= 1'b1;
    @(posedge ref_clk);
    rdEn <= 1'b0;
    #1;
    d = rdData;
  endtask

  // The timer is stopped and zeroed first so every run starts at BOTTOM.
  task automatic cfg(input logic [7:0] ca, input logic [7:0] cb,
                     input logic [15:0] cap, input logic [15:0] cmpA,
                     input logic [15:0] cmpB);
    wr(dsp_pkg::ADDR_CTRL_B, 8'h00);
    wr16(dsp_pkg::ADDR_CNT_L, 16'h0000);
    wr16(dsp_pkg::ADDR_CAP_L, cap);
    wr16(dsp_pkg::ADDR_CMPA_L, cmpA);
    wr16(dsp_pkg::ADDR_CMPB_L, cmpB);
    wr(dsp_pkg::ADDR_CTRL_A, ca);
    wr(dsp_pkg::ADDR_PINDIR, 8'h03);
    wr(dsp_pkg::ADDR_CTRL_B, cb);
  endtask

  // High time over one window is independent of the window's phase.
  task automatic duty(input int n, input logic [15:0] expA,
                      input logic [15:0] expB, input logic [1:0] expOe);
    logic [15:0] hiA;
    logic [15:0] hiB;
    hiA = 16'h0000;
    hiB = 16'h0000;
    repeat (2 * n) @(posedge ref_clk);
    repeat (n)
    begin
      @(posedge ref_clk);
      #1;
      hiA = hiA + {15'h0000, waveformOutputA};
      hiB = hiB + {15'h0000, waveformOutputB};
    end
    check("high time A", hiA, expA);
    check("high time B", hiB, expB);
    check("enables", {14'h0, waveformOutputAOe, waveformOutputBOe},
          {14'h0, expOe});
  endtask

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    stop_test;
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial
  begin
    nrst   = 1'b0;
    ce     = 1'b1;
    addr   = 8'h00;
    wrData = 8'h00;
    wrEn   = 1'b0;
    rdEn   = 1'b0;
    repeat (6) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(dsp_pkg::ADDR_CTRL_A, rv);
    check("ctrl A reset", {8'h00, rv}, 16'h0000);
    wr(dsp_pkg::ADDR_CTRL_A, 8'hFF);
    rd(dsp_pkg::ADDR_CTRL_A, rv);
    check("ctrl A mask", {8'h00, rv}, 16'h00F3);
    wr(dsp_pkg::ADDR_CTRL_B, 8'hFF);
    rd(dsp_pkg::ADDR_CTRL_B, rv);
    check("ctrl B mask", {8'h00, rv}, 16'h001F);
    rd(8'h90, rv);
    check("unmapped", {8'h00, rv}, 16'h0000);
    cfg(8'h21, 8'h11, 16'h0000, 16'h0003, 16'h0001);
    duty(6, 16'h0000, 16'h0002, 2'b01);
    @(posedge ref_clk);
    ce <= 1'b0;
    wr(dsp_pkg::ADDR_CTRL_A, 8'h00);
    @(posedge ref_clk);
    ce <= 1'b1;
    rd(dsp_pkg::ADDR_CTRL_A, rv);
    check("write with ce low", {8'h00, rv}, 16'h0021);
    cfg(8'h71, 8'h11, 16'h0000, 16'h0003, 16'h0001);
    duty(12, 16'h0006, 16'h0008, 2'b11);
    cfg(8'h60, 8'h11, 16'h0004, 16'h0001, 16'h0000);
    duty(8, 16'h0000, 16'h0000, 2'b01);
    cfg(8'hA0, 8'h11, 16'h0004, 16'h0002, 16'h0004);
    duty(8, 16'h0004, 16'h0008, 2'b11);
    cfg(8'hF0, 8'h11, 16'h0004, 16'h0000, 16'h0004);
    duty(8, 16'h0008, 16'h0000, 2'b11);
    cfg(8'hB2, 8'h19, 16'h0004, 16'h0001, 16'h0001);
    duty(5, 16'h0002, 16'h0003, 2'b11);
    cfg(8'h53, 8'h19, 16'h0000, 16'h0004, 16'h0002);
    duty(10, 16'h0005, 16'h0000, 2'b10);
    wr(dsp_pkg::ADDR_PINDIR, 8'h00);
    repeat (3) @(posedge ref_clk);
    check("dir off", {14'h0, waveformOutputAOe, waveformOutputBOe},
          16'h0000);
    for (int i = 0; i < 4; i++)
    begin
      cfg(8'h21, 8'h12 + 8'(i), 16'h0000, 16'h0003, 16'h0001);
      duty(6 * div[i], 16'h0000, 16'(2 * div[i]), 2'b01);
    end
    cfg(8'h21, 8'h11, 16'h0000, 16'h0003, 16'h0005);
    wr(dsp_pkg::ADDR_FLAGS, 8'h0F);
    repeat (20) @(posedge ref_clk);
    rd(dsp_pkg::ADDR_FLAGS, rv);
    check("flags mode 9", {8'h00, rv}, 16'h0003);
    cfg(8'h20, 8'h11, 16'h0004, 16'h0007, 16'h0002);
    wr(dsp_pkg::ADDR_FLAGS, 8'h0F);
    repeat (20) @(posedge ref_clk);
    rd(dsp_pkg::ADDR_FLAGS, rv);
    check("flags mode 8", {8'h00, rv}, 16'h000D);
    for (int i = 3; i >= 1; i--)
    begin
      cfg({2'b00, 2'(i), 4'h0}, 8'h01, 16'h0000, 16'h0000, 16'h0002);
      repeat (8) @(posedge ref_clk);
      check("normal B", {15'h0, waveformOutputB},
            {15'h0, i != 2});
    end
    stop_test;
  end
endmodule
`default_nettype wire
